// ===== verilog/spi_queue_and_fault_logic.sv
// spi unit core: divider, shift engine, queue, receive and fault flags
// assumes pins are resolved outside from the enables; pin inputs are asynchronous
// Function
// - master data write starts a transfer
// - phase sets idle or active first edge
// - master start delay within one bit
// - divided master clock runs only when enabled
// - queued byte follows; else shift register resent
// - write clears tx empty; move sets it
// - completed byte sets rx full; two-read clear
// - idle full buffer reloads shift register quickly
// - overrun set at bit 1 capture
// - overrun blocks receive register and flag
// - status read then data read clears overrun
// - one shared receive and error interrupt
// - master select sets pin directions
// - mode fault needs enable; flag kept
// - master low select: fault, disable, reset
// - slave select high mid-transfer: fault only
// - slave transfer span depends on phase
// - phase 0 select-deselect faults without clocks
// - deselected slave tristates and ignores clocks
// - status read then control write clears fault
// - disable aborts, empties, resets, keeps flags
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module spi_queue_and_fault_logic
    import spi_queue_pkg::*;
(
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    input  wire logic [spi_queue_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [spi_queue_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    output logic      [spi_queue_pkg::DATA_W-1:0] reg_rdata,
    output logic                               irq,
    input  wire logic                          sclk_in,
    output logic                               sclk_out,
    output logic                               sclk_oe,
    input  wire logic                          mosi_in,
    output logic                               mosi_out,
    output logic                               mosi_oe,
    input  wire logic                          miso_in,
    output logic                               miso_out,
    output logic                               miso_oe,
    input  wire logic                          ss_n_in
);
    import spi_queue_pkg::*;

    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [3:0]  s3;
    logic [3:0]  filt;
    logic        module_enable;
    logic        master_select;
    logic        clock_phase;
    logic        clock_polarity;
    logic        rx_irq_enable;
    logic        error_irq_enable;
    logic        mode_fault_enable;
    logic [1:0]  rate_select;
    logic        buffer_full;
    logic [7:0]  tx_buffer;
    logic [7:0]  rx_data;
    logic        rx_full_flag;
    logic        overrun_flag;
    logic        mode_fault_flag;
    logic        rx_armed;
    logic        ovr_armed;
    logic        mode_fault_flag_armed;
    logic [6:0]  div_cnt;
    logic [6:0]  half_m1;
    logic        sclk_prev;
    logic        ss_prev;
    xfer_state_t xfer;
    logic [4:0]  edge_n;
    logic [3:0]  samples;
    logic        sample_bit;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic        move;

    // pin order: 0 miso, 1 mosi, 2 sclk, 3 select (active low)
    wire [3:0] pin_raw = {ss_n_in, sclk_in, mosi_in, miso_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1[gi]   <= SYNC_RESET[gi];
                    s2[gi]   <= SYNC_RESET[gi];
                    s3[gi]   <= SYNC_RESET[gi];
                    filt[gi] <= SYNC_RESET[gi];
                end
                else
                begin
                    s1[gi] <= pin_raw[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi])
                        filt[gi] <= s3[gi];
                end
            end
        end
    endgenerate

    wire ss_high     = filt[3];
    wire master_mode = module_enable & master_select;
    wire slave_mode  = module_enable & !master_select;
    wire wr_ctrl     = reg_write && (reg_addr == CONTROL_REG_ADDR);
    wire wr_stat     = reg_write && (reg_addr == STATUS_CONTROL_REG_ADDR);
    wire wr_data     = reg_write && (reg_addr == DATA_BUFFER_REG_ADDR);
    wire rd_stat     = reg_read && (reg_addr == STATUS_CONTROL_REG_ADDR);
    wire rd_data     = reg_read && (reg_addr == DATA_BUFFER_REG_ADDR);

    always_comb
    begin
        case (rate_select)
            DIVIDE_BY_TWO:        half_m1 = HALF_M1_DIVIDE_BY_TWO;
            DIVIDE_BY_EIGHT:      half_m1 = HALF_M1_DIVIDE_BY_EIGHT;
            DIVIDE_BY_THIRTY_TWO: half_m1 = HALF_M1_DIVIDE_BY_THIRTY_TWO;
            default:              half_m1 = HALF_M1_DIVIDE_BY_ONE_TWENTY_EIGHT;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            div_cnt <= 7'h00;
        else if (!master_mode || div_cnt == half_m1)
            div_cnt <= 7'h00;
        else
            div_cnt <= div_cnt + 7'h01;
    end

    wire tick = master_mode && (div_cnt == half_m1);

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_prev <= 1'b0;
            ss_prev   <= 1'b1;
        end
        else
        begin
            sclk_prev <= filt[2];
            ss_prev   <= ss_high;
        end
    end

    // a deselected slave sees no clock edges
    wire slave_edge = slave_mode && !ss_high && (filt[2] != sclk_prev);
    wire ev         = master_select ? tick : slave_edge;
    wire active     = (xfer == xfer_shifting);
    wire din        = master_select ? filt[0] : filt[1];
    wire [4:0] n_next   = edge_n + 5'h01;
    wire       is_samp  = clock_phase ? !n_next[0] : n_next[0];
    wire       step     = active && ev;
    wire       done     = step && (n_next == EDGES_PER_FRAME);
    wire [7:0] rx_byte  = {shift[6:0], clock_phase ? din : sample_bit};

    // start on the next half-bit tick after the write
    wire master_start = tick && !active && buffer_full;
    // phase 0 starts at select fall, phase 1 at the first clock edge
    wire slave_start  = slave_mode && !active &&
                        (clock_phase ? slave_edge : (ss_prev && !ss_high));
    wire start        = master_start || slave_start;

    wire fault_cond   = module_enable && mode_fault_enable &&
                        (master_select ? !ss_high : (active && ss_high));
    wire master_fault = fault_cond && master_select;

    always_comb
    begin
        next_shift = shift;
        move       = 1'b0;
        if (!module_enable || master_fault)
            next_shift = 8'h00;
        else
        begin
            if (step && !is_samp && samples != 4'h0)
                next_shift = {shift[6:0], sample_bit};
            if (done)
                next_shift = rx_byte;
            if (buffer_full && (master_start || (!master_select && (!active || done))))
            begin
                next_shift = tx_buffer;
                move       = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            shift <= 8'h00;
        else
            shift <= next_shift;
    end

    // disable or master fault clears the state counter
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            xfer       <= xfer_idle;
            edge_n     <= 5'h00;
            samples    <= 4'h0;
            sample_bit <= 1'b0;
        end
        else if (!module_enable || master_fault)
        begin
            xfer    <= xfer_idle;
            edge_n  <= 5'h00;
            samples <= 4'h0;
        end
        else
        begin
            case (xfer)
                xfer_idle:
                begin
                    if (start)
                    begin
                        xfer    <= xfer_shifting;
                        samples <= 4'h0;
                        // phase 1: the start itself is the first edge
                        edge_n  <= clock_phase ? 5'h01 : 5'h00;
                    end
                end
                xfer_shifting:
                begin
                    if (done)
                        xfer <= xfer_idle;
                    if (step)
                    begin
                        edge_n <= n_next;
                        if (is_samp)
                        begin
                            sample_bit <= din;
                            samples    <= samples + 4'h1;
                        end
                    end
                end
                default: xfer <= xfer_idle;
            endcase
        end
    end

    // phase 0 holds idle level first; phase 1 opens with a leading edge
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            sclk_out <= 1'b0;
        else if (!master_mode || master_fault || (!active && !master_start))
            sclk_out <= clock_polarity;
        else if (master_start)
            sclk_out <= clock_phase ? !clock_polarity : clock_polarity;
        else if (step)
            sclk_out <= !sclk_out;
    end

    // directions follow master select; deselected slave floats
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_oe  <= 1'b0;
            mosi_oe  <= 1'b0;
            miso_oe  <= 1'b0;
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
        end
        else
        begin
            sclk_oe  <= master_mode && !master_fault;
            mosi_oe  <= master_mode && !master_fault;
            miso_oe  <= slave_mode && !ss_high;
            mosi_out <= next_shift[7];
            miso_out <= next_shift[7];
        end
    end

    // transmit buffer; a write in a move cycle keeps the new byte
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buffer_full <= 1'b0;
            tx_buffer   <= 8'h00;
        end
        else
        begin
            if (wr_data)
                tx_buffer <= reg_wdata;
            if (!module_enable || master_fault)
                buffer_full <= 1'b0;
            else if (wr_data)
                buffer_full <= 1'b1;
            else if (move)
                buffer_full <= 1'b0;
        end
    end

    wire bit1_strobe = step && is_samp && (samples == BIT1_SAMPLE - 4'h1);

    // receive register and full flag; set beats clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_data      <= 8'h00;
            rx_full_flag <= 1'b0;
            rx_armed     <= 1'b0;
        end
        else
        begin
            if (done && !overrun_flag)
                rx_data <= rx_byte;
            if (done && !overrun_flag)
                rx_full_flag <= 1'b1;
            else if (rd_data && rx_armed)
                rx_full_flag <= 1'b0;
            if (rd_stat && rx_full_flag)
                rx_armed <= 1'b1;
            else if (rd_data)
                rx_armed <= 1'b0;
        end
    end

    // overrun at the bit 1 capture, two-read clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            overrun_flag <= 1'b0;
            ovr_armed    <= 1'b0;
        end
        else
        begin
            if (bit1_strobe && rx_full_flag)
                overrun_flag <= 1'b1;
            else if (rd_data && ovr_armed)
                overrun_flag <= 1'b0;
            if (rd_stat && overrun_flag)
                ovr_armed <= 1'b1;
            else if (rd_data)
                ovr_armed <= 1'b0;
        end
    end

    // fault flag; clearing fails while the condition stands
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed      <= 1'b0;
        end
        else
        begin
            if (fault_cond)
                mode_fault_flag <= 1'b1;
            else if (wr_ctrl && mode_fault_flag_armed)
                mode_fault_flag <= 1'b0;
            if (fault_cond)
                mode_fault_flag_armed <= 1'b0;
            else if (rd_stat && mode_fault_flag)
                mode_fault_flag_armed <= 1'b1;
            else if (wr_ctrl)
                mode_fault_flag_armed <= 1'b0;
        end
    end

    // master fault drops module enable; slave fault does not
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            module_enable     <= CONTROL_RESET[CTL_MODULE_ENABLE];
            master_select     <= CONTROL_RESET[CTL_MASTER_SELECT];
            clock_phase       <= CONTROL_RESET[CTL_CLOCK_PHASE];
            clock_polarity    <= CONTROL_RESET[CTL_CLOCK_POLARITY];
            rx_irq_enable     <= CONTROL_RESET[CTL_RX_IRQ_ENABLE];
            error_irq_enable  <= STATUS_RESET[STS_ERROR_IRQ_ENABLE];
            mode_fault_enable <= STATUS_RESET[STS_MODE_FAULT_ENABLE];
            rate_select       <= STATUS_RESET[STS_RATE_HI:STS_RATE_LO];
        end
        else
        begin
            if (master_fault)
                module_enable <= 1'b0;
            else if (wr_ctrl)
                module_enable <= reg_wdata[CTL_MODULE_ENABLE];
            if (wr_ctrl)
            begin
                master_select  <= reg_wdata[CTL_MASTER_SELECT];
                clock_phase    <= reg_wdata[CTL_CLOCK_PHASE];
                clock_polarity <= reg_wdata[CTL_CLOCK_POLARITY];
                rx_irq_enable  <= reg_wdata[CTL_RX_IRQ_ENABLE];
            end
            if (wr_stat)
            begin
                error_irq_enable  <= reg_wdata[STS_ERROR_IRQ_ENABLE];
                mode_fault_enable <= reg_wdata[STS_MODE_FAULT_ENABLE];
                rate_select       <= reg_wdata[STS_RATE_HI:STS_RATE_LO];
            end
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (!reg_read)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                CONTROL_REG_ADDR:
                    reg_rdata <= {3'h0, master_select, clock_polarity, clock_phase,
                                  module_enable, rx_irq_enable};
                STATUS_CONTROL_REG_ADDR:
                    reg_rdata <= {rx_full_flag, error_irq_enable, overrun_flag,
                                  mode_fault_flag, !buffer_full, mode_fault_enable,
                                  rate_select};
                DATA_BUFFER_REG_ADDR:
                    reg_rdata <= rx_data;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // error enable gates overrun and fault together
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= (rx_full_flag && rx_irq_enable) ||
                   (error_irq_enable && (overrun_flag || mode_fault_flag));
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_start_latency: assert property (
        (wr_data && master_mode && !active && !buffer_full)
        |-> ##[1:130] (active || !module_enable))
        else $error("master transfer did not start within one bit time");
    a_tx_empty_clear: assert property (
        (wr_data && module_enable && !master_fault) |=> buffer_full)
        else $error("data write did not clear tx empty");
    a_rx_full_set: assert property (
        (done && !overrun_flag && module_enable) |=> (rx_full_flag && rx_data == $past(rx_byte)))
        else $error("completed byte not posted");
    a_overrun_hold: assert property (
        (overrun_flag && done) |=> $stable(rx_data))
        else $error("receive register changed during overrun");
    a_mode_fault_flag_needs_en: assert property (
        $rose(mode_fault_flag) |-> $past(mode_fault_enable))
        else $error("mode fault set without enable");
    a_master_fault_off: assert property (
        master_fault |=> (!module_enable && !buffer_full && !active))
        else $error("master fault did not disable the unit");
    a_slave_fault_keep: assert property (
        (fault_cond && !master_select && !wr_ctrl) |=> module_enable)
        else $error("slave fault changed module enable");
    a_miso_float: assert property (
        (ss_high || master_select) |=> !miso_oe)
        else $error("miso driven while not selected slave");
    a_disable_idle: assert property (
        !module_enable |=> (!active && !buffer_full && shift == 8'h00))
        else $error("disabled unit not reset");
    a_phase0_idle: assert property (
        (master_start && !clock_phase && !master_fault) |=> (sclk_out == $past(clock_polarity)))
        else $error("phase 0 first half not idle");

    c_master_frame: cover property (master_start ##[1:300] done);
    c_overrun: cover property ($rose(overrun_flag));
    c_slave_fault: cover property (fault_cond && !master_select);
    c_back_to_back: cover property (done && buffer_full && master_select);

endmodule

// ===== verilog/spi_queue_pkg.sv
// constants for the spi transfer queue and fault logic
// assumes an 8-bit register port with three registers and an 8-bit frame
package spi_queue_pkg;

    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    // register indices on the plain register port
    localparam logic [1:0] CONTROL_REG_ADDR        = 2'h0;
    localparam logic [1:0] STATUS_CONTROL_REG_ADDR = 2'h1;
    localparam logic [1:0] DATA_BUFFER_REG_ADDR    = 2'h2;

    // control_reg fields
    localparam int unsigned CTL_RX_IRQ_ENABLE  = 0;
    localparam int unsigned CTL_MODULE_ENABLE  = 1;
    localparam int unsigned CTL_CLOCK_PHASE    = 2;
    localparam int unsigned CTL_CLOCK_POLARITY = 3;
    localparam int unsigned CTL_MASTER_SELECT  = 4;

    // status_control_reg fields
    localparam int unsigned STS_RATE_LO           = 0;
    localparam int unsigned STS_RATE_HI           = 1;
    localparam int unsigned STS_MODE_FAULT_ENABLE = 2;
    localparam int unsigned STS_TX_EMPTY          = 3;
    localparam int unsigned STS_MODE_FAULT        = 4;
    localparam int unsigned STS_OVERRUN           = 5;
    localparam int unsigned STS_ERROR_IRQ_ENABLE  = 6;
    localparam int unsigned STS_RX_FULL           = 7;

    // rate_select encodings
    localparam logic [1:0] DIVIDE_BY_TWO              = 2'h0;
    localparam logic [1:0] DIVIDE_BY_EIGHT            = 2'h1;
    localparam logic [1:0] DIVIDE_BY_THIRTY_TWO       = 2'h2;
    localparam logic [1:0] DIVIDE_BY_ONE_TWENTY_EIGHT = 2'h3;

    // half a bit time in bus cycles, minus one
    localparam logic [6:0] HALF_M1_DIVIDE_BY_TWO   = 7'h00;
    localparam logic [6:0] HALF_M1_DIVIDE_BY_EIGHT   = 7'h03;
    localparam logic [6:0] HALF_M1_DIVIDE_BY_THIRTY_TWO  = 7'h0F;
    localparam logic [6:0] HALF_M1_DIVIDE_BY_ONE_TWENTY_EIGHT = 7'h3F;

    // clock edges per frame and the sample that carries bit 1
    localparam logic [4:0] EDGES_PER_FRAME = 5'h10;
    localparam logic [3:0] BIT1_SAMPLE     = 4'h7;

    // synchroniser reset: select high, clock and data low
    localparam logic [3:0] SYNC_RESET = 4'h8;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;

    typedef enum logic {xfer_idle, xfer_shifting} xfer_state_t;

endpackage

// ===== test/spi_far_slave.sv
// far-side spi slave model, phase 0, polarity 0
// assumes the block is master and the bench drives the select
`timescale 1ns/1ps
module spi_far_slave
(
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh;
    logic [3:0] cnt;

    initial
    begin
        sh = 8'h00;
        cnt = 4'h0;
        rx_byte = 8'h00;
    end

    always @(negedge sel_n)
    begin
        sh = tx_byte;
        cnt = 4'h0;
    end

    always @(posedge sclk)
    begin
        if (!sel_n)
            rx_byte = {rx_byte[6:0], mosi};
    end

    always @(negedge sclk)
    begin
        if (!sel_n)
        begin
            cnt = cnt + 4'h1;
            sh = (cnt == 4'h8) ? tx_byte : {sh[6:0], 1'b0};
            if (cnt == 4'h8)
                cnt = 4'h0;
        end
    end

    assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

// ===== test/spi_queue_and_fault_logic_bench.sv
// bench for the spi queue and fault logic, block as master
// assumes a far slave model and a 50 MHz bus clock
`timescale 1ns/1ps
module spi_queue_and_fault_logic_bench;
    import spi_queue_pkg::*;
    logic       core_clk, rstn, reg_write, reg_read, ss_n_in, sel_n, irq;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, far_tx, far_rx, d;
    logic       sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, far_miso;
    int         failures, n_checks;

    spi_queue_and_fault_logic uut (.core_clk(core_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .sclk_in(sclk_oe ? sclk_out : 1'b0), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .mosi_in(mosi_oe ? mosi_out : 1'b0), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_oe ? miso_out : far_miso), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_n_in(ss_n_in));
    spi_far_slave far (.sclk(sclk_oe ? sclk_out : 1'b0),
        .mosi(mosi_oe ? mosi_out : 1'b0), .sel_n(sel_n), .tx_byte(far_tx),
        .miso(far_miso), .rx_byte(far_rx));

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wirq();
        int i;
        for (i = 0; i < 600 && irq !== 1'b1; i++)
            @(posedge core_clk);
        chk({7'h00, irq}, 8'h01);
    endtask

    task automatic t_reset();
        rd(CONTROL_REG_ADDR);
        chk(d, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3);
        chk(d, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_xfer();
        far_tx = 8'h3C;
        sel_n <= 1'b0;
        // divide by 32: the four-flop input path needs a slow enough bit time
        wr(STATUS_CONTROL_REG_ADDR, 8'h02);
        wr(CONTROL_REG_ADDR, 8'h13);
        @(posedge core_clk);
        #1 chk({5'h00, sclk_oe, mosi_oe, miso_oe}, 8'h06);
        wr(DATA_BUFFER_REG_ADDR, 8'hA5);
        wirq();
        rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'h80, 8'h80);
        rd(DATA_BUFFER_REG_ADDR);
        chk(d, 8'h3C);
        chk(far_rx, 8'hA5);
        rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'h80, 8'h00);
        chk({7'h00, sclk_out}, 8'h00);
        $display("test transfer done");
    endtask

    task automatic t_queue();
        int i;
        far_tx = 8'h5A;
        // reselect the far slave so that it loads the new byte
        sel_n <= 1'b1;
        @(posedge core_clk);
        sel_n <= 1'b0;
        wr(CONTROL_REG_ADDR, 8'h12);
        wr(STATUS_CONTROL_REG_ADDR, 8'h42);
        wr(DATA_BUFFER_REG_ADDR, 8'h11);
        rd(STATUS_CONTROL_REG_ADDR);
        for (i = 0; i < 40 && d[STS_TX_EMPTY] !== 1'b1; i++)
            rd(STATUS_CONTROL_REG_ADDR);
        wr(DATA_BUFFER_REG_ADDR, 8'h22);
        rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'h08, 8'h00);
        for (i = 0; i < 400 && d[STS_OVERRUN] !== 1'b1; i++)
            rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'hA8, 8'hA8);
        chk({7'h00, irq}, 8'h01);
        // overrun comes at bit 1; let the second frame finish
        repeat (64) @(posedge core_clk);
        chk(far_rx, 8'h22);
        rd(DATA_BUFFER_REG_ADDR);
        chk(d, 8'h5A);
        rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'hA0, 8'h00);
        $display("test queue done");
    endtask

    task automatic t_fault();
        wr(STATUS_CONTROL_REG_ADDR, 8'h44);
        wr(CONTROL_REG_ADDR, 8'h13);
        ss_n_in <= 1'b0;
        wirq();
        rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'h18, 8'h18);
        rd(CONTROL_REG_ADDR);
        chk(d & 8'h02, 8'h00);
        ss_n_in <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(STATUS_CONTROL_REG_ADDR);
        wr(CONTROL_REG_ADDR, 8'h10);
        rd(STATUS_CONTROL_REG_ADDR);
        chk(d & 8'h10, 8'h00);
        $display("test fault done");
    endtask

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        failures++;
        results();
    end

    initial
    begin
        failures = 0;
        n_checks = 0;
        rstn = 1'b0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        ss_n_in = 1'b1;
        sel_n = 1'b1;
        far_tx = 8'h00;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_xfer();
        t_queue();
        t_fault();
        results();
    end
endmodule
